// file: logic/csf_debounce.sv
// synchroniser and debouncer for one comparator result
module csf_debounce #(
    parameter int DEB_CYC = 8
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // raw and filtered level
    input wire logic raw_i,
    output logic level_o
);
    localparam int CW = $clog2(DEB_CYC + 1);
    logic meta_q, sync_q;        // two-flop synchroniser
    logic [CW-1:0] cnt_q, cnt_d; // agreement counter
    logic lvl_q, lvl_d;          // accepted level

    // new level only after DEB_CYC stable samples
    always_comb begin
        cnt_d = '0;
        lvl_d = lvl_q;
        if (sync_q != lvl_q) begin
            if (cnt_q == CW'(DEB_CYC - 1)) begin
                lvl_d = sync_q;
            end else begin
                cnt_d = cnt_q + 1'b1;
            end
        end
    end

    // registers only
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            cnt_q <= '0;
            lvl_q <= 1'b0;
        end else begin
            meta_q <= raw_i;
            sync_q <= meta_q;
            cnt_q <= cnt_d;
            lvl_q <= lvl_d;
        end
    end

    assign level_o = lvl_q;
endmodule // csf_debounce

// file: logic/csf_pkg.sv
// shared constants and carrier types of the charger supervisor
package csf_pkg;
    // reference clock
    localparam longint CSF_CLK_HZ = 40_000_000;
    // times in their own units
    localparam longint CSF_CHG_TIMER_MIN = 32;  // charge safety timer
    localparam longint CSF_BST_TIMER_S = 32;    // boost safety timer
    localparam longint CSF_DET_MS = 30;         // bad source detection window
    localparam longint CSF_RETRY_S = 2;         // bad source retry period
    localparam longint CSF_OL_MS = 30;          // boost overload persistence
    localparam longint CSF_PULSE_US = 10;       // indicator fault pulse width
    localparam longint CSF_DEB_NS = 200;        // comparator debounce time
    // derived cycle counts; long ones round down, debounce rounds up
    localparam longint CSF_CHG_TIMER_CYC = CSF_CHG_TIMER_MIN * 60 * CSF_CLK_HZ;
    localparam longint CSF_BST_TIMER_CYC = CSF_BST_TIMER_S * CSF_CLK_HZ;
    localparam longint CSF_DET_CYC = CSF_DET_MS * CSF_CLK_HZ / 1000;
    localparam longint CSF_RETRY_CYC = CSF_RETRY_S * CSF_CLK_HZ;
    localparam longint CSF_OL_CYC = CSF_OL_MS * CSF_CLK_HZ / 1000;
    localparam int CSF_PULSE_CYC = int'(CSF_PULSE_US * CSF_CLK_HZ / 1_000_000);
    localparam int CSF_DEB_CYC = int'((CSF_DEB_NS * CSF_CLK_HZ + 999_999_999) / 1_000_000_000);
    // end-of-charge threshold: code 0 means 1 mV, steps of 1 mV
    localparam logic [3:0] CSF_EOC_BASE_MV = 4'h1;
    // charge mode selector encodings
    localparam logic [1:0] CSF_SEL_BOOST = 2'h1;
    localparam logic [1:0] CSF_SEL_NOTIFY = 2'h2;
    localparam logic [1:0] CSF_SEL_AUTO = 2'h3;
    // indicator select encodings
    localparam logic [1:0] CSF_IND_STATUS = 2'h0;
    localparam logic [1:0] CSF_IND_LOW = 2'h1;
    localparam logic [1:0] CSF_IND_HIZ = 2'h2;
    localparam int CSF_NCMP = 11;

    // debounced comparator results
    typedef struct packed {
        logic supply_ok;     // supply above minimum
        logic sleep;         // headroom below sleep level
        logic in_ov;         // supply overvoltage
        logic bat_low_rech;  // battery below regulation minus recharge
        logic bat_ov;        // battery overvoltage, charge mode
        logic out_ov;        // boost output overvoltage
        logic bst_bat_hi;    // battery above boost maximum
        logic bst_bat_lo;    // battery below boost minimum
        logic overload;      // boost in current limit
        logic cv_mode;       // constant-voltage loop dominant
        logic below_term;    // charge current below threshold
    } csf_cmp_s;

    // sticky event flags
    typedef struct packed {
        logic recharge_needed_flag;
        logic charge_timer_expired_flag;
        logic bad_source_flag;
        logic sleep_condition_flag;
        logic input_overvoltage_flag;
        logic boost_timer_expired_flag;
        logic boost_output_overvoltage_flag;
        logic boost_overload_flag;
        logic charge_battery_overvoltage_flag;
        logic boost_battery_overvoltage_flag;
        logic boost_battery_undervoltage_flag;
    } csf_flags_s;

    // one-hot supervisor states
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_DETECT = 7'h02,
        ST_BADWAIT = 7'h04,
        ST_CHARGE = 7'h08,
        ST_DONE = 7'h10,
        ST_HIZ = 7'h20,
        ST_BOOST = 7'h40
    } csf_state_e;
endpackage

// file: logic/csf_supervisor.sv
// charger and boost supervisory state machine
// Operation
// - threshold code maps to 1..8 mV
// - selector 11 recharges automatically on low battery
// - selector 10 flags recharge need, alerts host
// - charge timer starts, restarts on host access
// - charge timer expiry: high-z, defaults, flag
// - supply rise: detection sink for window
// - detection pass charges, fail flags and retries
// - sleep turns off blocking switch and switching
// - input overvoltage pauses charge, flags, pulses indicator
// - boost by selector 01 or pin path
// - boost timer expiry: high-z, defaults, flag
// - boost output overvoltage: stop, high-z
// - overload beyond window: fault, defaults
// - indicator select 00 shows charging
// - indicator select 01 low, 10 high-z
// - battery overvoltage pauses, release resumes with defaults
// - boost battery out of range: high-z
// - termination ends charge below threshold in CV
// - new cycle on supply rise, or on selector rise in done or high-z
// - masks gate only the alert pin
module csf_supervisor import csf_pkg::*; #(
    parameter int TMR_W = 40,
    parameter longint CHG_TIMER_CYC = CSF_CHG_TIMER_CYC,
    parameter longint BST_TIMER_CYC = CSF_BST_TIMER_CYC,
    parameter longint DET_CYC = CSF_DET_CYC,
    parameter longint RETRY_CYC = CSF_RETRY_CYC,
    parameter longint OL_CYC = CSF_OL_CYC
) (
    // clock and reset
    input wire logic CLOCK_I,
    input wire logic RST_I,
    // analog comparators, raw
    input wire csf_cmp_s CMP_I,
    // host configuration
    input wire logic [1:0] CHARGE_MODE_SELECT_I,
    input wire logic TERM_ENABLE_I,
    input wire logic [2:0] EOC_THRESHOLD_CODE_I,
    input wire logic [1:0] IND_SELECT_I,
    input wire logic PIN_BOOST_ENABLE_I,
    input wire logic PIN_BOOST_POLARITY_I,
    input wire logic BOOST_REQUEST_PIN_I,
    // host access and flag handling
    input wire logic HOST_ACCESS_I,
    input wire csf_flags_s FLAG_CLEAR_I,
    input wire csf_flags_s FLAG_MASK_I,
    // status to host
    output csf_flags_s FLAGS_O,
    output logic ALERT_O,
    output logic ALERT_OE_N_O,
    output logic IND_O,
    output logic IND_OE_N_O,
    // power stage control
    output logic [3:0] EOC_THRESHOLD_MV_O,
    output logic DET_SINK_EN_O,
    output logic PWM_EN_O,
    output logic REV_SWITCH_EN_O,
    output logic REG_DEFAULT_O,
    output logic CHARGING_O,
    output logic BOOST_O,
    output logic HIZ_O
);
    localparam int PW = $clog2(CSF_PULSE_CYC + 1);

    logic [CSF_NCMP-1:0] cmp_raw; // raw comparator vector
    logic [CSF_NCMP-1:0] cmp_vec; // filtered vector
    csf_cmp_s cmp;                // filtered results
    csf_state_e st_q, st_d;       // supervisor state
    csf_flags_s flags_q, flags_d; // sticky flags
    csf_flags_s set_f, clr_f;     // hardware set and release clear
    logic sup_q, sel1_q, batov_q, inov_q, pin_q; // previous levels
    logic pin_arm_q, pin_arm_d;   // pin boost request armed
    logic [PW-1:0] pulse_q, pulse_d; // indicator fault pulse
    logic sup_rise, sel_rise, boost_req, chg_on;
    logic saf_load, saf_run, saf_done;
    logic det_load, det_run, det_done;
    logic ol_load, ol_run, ol_done;
    logic [TMR_W-1:0] saf_cnt, det_cnt;
    logic regdef_d, pwm_d, rev_d, ind_oe_n_d, alert_oe_n_d;
    logic [3:0] eoc_d;
    logic regdef_q, pwm_q, rev_q, sink_q, ind_oe_n_q, alert_oe_n_q;
    logic chg_q, bst_q, hiz_q;
    logic [3:0] eoc_q;

    // filter every comparator before it can steer state
    assign cmp_raw = CMP_I;
    for (genvar i = 0; i < CSF_NCMP; i++) begin : g_deb
        csf_debounce #(.DEB_CYC(CSF_DEB_CYC)) u_deb (
            .clk_i(CLOCK_I),
            .rst_i(RST_I),
            .raw_i(cmp_raw[i]),
            .level_o(cmp_vec[i])
        );
    end
    assign cmp = cmp_vec;

    // edges of supply and selector, and the boost request
    assign sup_rise = cmp.supply_ok && !sup_q;
    assign sel_rise = CHARGE_MODE_SELECT_I[1] && !sel1_q;
    assign boost_req = (CHARGE_MODE_SELECT_I == CSF_SEL_BOOST) ||
        (PIN_BOOST_ENABLE_I && pin_arm_q);
    // paused while any input-side protection is active
    assign chg_on = (st_q == ST_CHARGE) && !cmp.in_ov && !cmp.bat_ov && !cmp.sleep;

    // pin request: armed by an edge, held by the polarity level
    always_comb begin
        pin_arm_d = pin_arm_q;
        if (BOOST_REQUEST_PIN_I != PIN_BOOST_POLARITY_I) begin
            pin_arm_d = 1'b0;
        end else if (BOOST_REQUEST_PIN_I != pin_q) begin
            pin_arm_d = 1'b1;
        end
    end

    // safety timer: one counter shared by charge and boost
    assign saf_run = (st_q == ST_CHARGE) || (st_q == ST_BOOST);
    assign saf_cnt = (st_d == ST_BOOST) ? TMR_W'(BST_TIMER_CYC) : TMR_W'(CHG_TIMER_CYC);
    assign saf_load = ((st_d != st_q) && ((st_d == ST_CHARGE) || (st_d == ST_BOOST))) ||
        (HOST_ACCESS_I && saf_run);
    csf_timer #(.W(TMR_W)) u_saf (
        .clk_i(CLOCK_I),
        .rst_i(RST_I),
        .load_i(saf_load),
        .count_i(saf_cnt),
        .run_i(saf_run),
        .done_o(saf_done)
    );

    // detection window and retry wait share a counter
    assign det_run = (st_q == ST_DETECT) || (st_q == ST_BADWAIT);
    assign det_cnt = (st_d == ST_BADWAIT) ? TMR_W'(RETRY_CYC) : TMR_W'(DET_CYC);
    assign det_load = (st_d != st_q) && ((st_d == ST_DETECT) || (st_d == ST_BADWAIT));
    csf_timer #(.W(TMR_W)) u_det (
        .clk_i(CLOCK_I),
        .rst_i(RST_I),
        .load_i(det_load),
        .count_i(det_cnt),
        .run_i(det_run),
        .done_o(det_done)
    );

    // overload must persist one cycle beyond the window
    assign ol_run = (st_q == ST_BOOST) && cmp.overload;
    assign ol_load = !ol_run;
    csf_timer #(.W(TMR_W)) u_ol (
        .clk_i(CLOCK_I),
        .rst_i(RST_I),
        .load_i(ol_load),
        .count_i(TMR_W'(OL_CYC + 1)),
        .run_i(ol_run),
        .done_o(ol_done)
    );

    // state transitions and flag events
    always_comb begin
        st_d = st_q;
        set_f = '0;
        clr_f = '0;
        regdef_d = 1'b0;
        case (st_q)
            ST_IDLE: begin
                if (boost_req) begin
                    st_d = ST_BOOST;
                end else if (sup_rise && CHARGE_MODE_SELECT_I[1]) begin
                    st_d = ST_DETECT;
                end
            end
            ST_DETECT: begin
                if (det_done) begin
                    if (cmp.supply_ok) begin
                        st_d = ST_CHARGE;
                    end else begin
                        st_d = ST_BADWAIT;
                        set_f.bad_source_flag = 1'b1;
                    end
                end
            end
            ST_BADWAIT: begin
                if (det_done) begin
                    st_d = ST_DETECT;
                end
            end
            ST_CHARGE: begin
                // protections stay active whatever the masks say
                set_f.sleep_condition_flag = cmp.sleep;
                set_f.input_overvoltage_flag = cmp.in_ov;
                set_f.charge_battery_overvoltage_flag = cmp.bat_ov;
                if (batov_q && !cmp.bat_ov) begin
                    clr_f.charge_battery_overvoltage_flag = 1'b1;
                    regdef_d = 1'b1;
                end
                if (saf_done) begin
                    st_d = ST_HIZ;
                    set_f.charge_timer_expired_flag = 1'b1;
                    regdef_d = 1'b1;
                end else if (!cmp.supply_ok || !CHARGE_MODE_SELECT_I[1]) begin
                    st_d = ST_IDLE;
                end else if (TERM_ENABLE_I && cmp.cv_mode && cmp.below_term && chg_on) begin
                    st_d = ST_DONE;
                end
            end
            ST_DONE: begin
                if (!cmp.supply_ok) begin
                    st_d = ST_IDLE;
                end else if (sel_rise) begin
                    st_d = ST_CHARGE;
                end else if (cmp.bat_low_rech && CHARGE_MODE_SELECT_I == CSF_SEL_AUTO) begin
                    st_d = ST_CHARGE;
                end else if (cmp.bat_low_rech && CHARGE_MODE_SELECT_I == CSF_SEL_NOTIFY) begin
                    set_f.recharge_needed_flag = 1'b1;
                end else if (boost_req) begin
                    st_d = ST_BOOST;
                end
            end
            ST_HIZ: begin
                // left by any boost request, or by a fresh supply or a selector rise with supply present
                if (boost_req) begin
                    st_d = ST_BOOST;
                end else if ((sup_rise || (sel_rise && cmp.supply_ok)) &&
                        CHARGE_MODE_SELECT_I[1]) begin
                    st_d = ST_DETECT;
                end
            end
            ST_BOOST: begin
                set_f.boost_output_overvoltage_flag = cmp.out_ov;
                set_f.boost_battery_overvoltage_flag = cmp.bst_bat_hi;
                set_f.boost_battery_undervoltage_flag = cmp.bst_bat_lo;
                if (cmp.out_ov || cmp.bst_bat_hi || cmp.bst_bat_lo) begin
                    st_d = ST_HIZ;
                end else if (saf_done) begin
                    st_d = ST_HIZ;
                    set_f.boost_timer_expired_flag = 1'b1;
                    regdef_d = 1'b1;
                end else if (ol_done) begin
                    st_d = ST_IDLE;
                    set_f.boost_overload_flag = 1'b1;
                    regdef_d = 1'b1;
                end else if (!boost_req) begin
                    st_d = ST_IDLE;
                end
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    // sticky flags: a set in the clearing cycle wins
    assign flags_d = (flags_q & ~FLAG_CLEAR_I & ~clr_f) | set_f;

    // fault pulse starts on the overvoltage edge
    always_comb begin
        pulse_d = pulse_q;
        if ((st_q == ST_CHARGE) && cmp.in_ov && !inov_q) begin
            pulse_d = PW'(CSF_PULSE_CYC);
        end else if (pulse_q != '0) begin
            pulse_d = pulse_q - 1'b1;
        end
    end

    // power stage, indicator and alert next values
    always_comb begin
        pwm_d = chg_on || (st_q == ST_BOOST);
        rev_d = ((st_q == ST_CHARGE) && !cmp.sleep) || (st_q == ST_BOOST);
        if (!TERM_ENABLE_I) begin
            eoc_d = 4'h0;
        end else begin
            eoc_d = {1'b0, EOC_THRESHOLD_CODE_I} + CSF_EOC_BASE_MV;
        end
        case (IND_SELECT_I)
            CSF_IND_STATUS: ind_oe_n_d = !(chg_on || (pulse_q != '0));
            CSF_IND_LOW: ind_oe_n_d = 1'b0;
            CSF_IND_HIZ: ind_oe_n_d = 1'b1;
            default: ind_oe_n_d = 1'b1;
        endcase
        // masks hide events from the pin, nothing else
        alert_oe_n_d = !(|(flags_q & ~FLAG_MASK_I));
    end

    // all registers of the block
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            st_q <= ST_IDLE;
            flags_q <= '0;
            sup_q <= 1'b0;
            sel1_q <= 1'b0;
            batov_q <= 1'b0;
            inov_q <= 1'b0;
            pin_q <= 1'b0;
            pin_arm_q <= 1'b0;
            pulse_q <= '0;
            regdef_q <= 1'b0;
            pwm_q <= 1'b0;
            rev_q <= 1'b0;
            sink_q <= 1'b0;
            ind_oe_n_q <= 1'b1;
            alert_oe_n_q <= 1'b1;
            eoc_q <= 4'h0;
            chg_q <= 1'b0;
            bst_q <= 1'b0;
            hiz_q <= 1'b0;
        end else begin
            st_q <= st_d;
            flags_q <= flags_d;
            sup_q <= cmp.supply_ok;
            sel1_q <= CHARGE_MODE_SELECT_I[1];
            batov_q <= cmp.bat_ov;
            inov_q <= cmp.in_ov;
            pin_q <= BOOST_REQUEST_PIN_I;
            pin_arm_q <= pin_arm_d;
            pulse_q <= pulse_d;
            regdef_q <= regdef_d;
            pwm_q <= pwm_d;
            rev_q <= rev_d;
            sink_q <= (st_q == ST_DETECT);
            ind_oe_n_q <= ind_oe_n_d;
            alert_oe_n_q <= alert_oe_n_d;
            eoc_q <= eoc_d;
            chg_q <= chg_on;
            bst_q <= (st_q == ST_BOOST);
            hiz_q <= (st_q == ST_HIZ);
        end
    end

    // open-drain pins only ever pull low
    assign ALERT_O = 1'b0;
    assign IND_O = 1'b0;
    assign FLAGS_O = flags_q;
    assign ALERT_OE_N_O = alert_oe_n_q;
    assign IND_OE_N_O = ind_oe_n_q;
    assign EOC_THRESHOLD_MV_O = eoc_q;
    assign DET_SINK_EN_O = sink_q;
    assign PWM_EN_O = pwm_q;
    assign REV_SWITCH_EN_O = rev_q;
    assign REG_DEFAULT_O = regdef_q;
    assign CHARGING_O = chg_q;
    assign BOOST_O = bst_q;
    assign HIZ_O = hiz_q;

    // checks
    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (RST_I);
    sequence s_hiz_next;
        ##1 (st_q == ST_HIZ) ##1 HIZ_O;
    endsequence
    property p_eoc;
        TERM_ENABLE_I |=> (EOC_THRESHOLD_MV_O == {1'b0, $past(EOC_THRESHOLD_CODE_I)} + 4'h1);
    endproperty
    a_eoc: assert property (p_eoc) else $error("eoc threshold wrong");
    property p_auto;
        (st_q == ST_DONE) && cmp.supply_ok && cmp.bat_low_rech && !sel_rise &&
            CHARGE_MODE_SELECT_I == CSF_SEL_AUTO |=> st_q == ST_CHARGE;
    endproperty
    a_auto: assert property (p_auto) else $error("no auto recharge");
    property p_notify;
        (st_q == ST_DONE) && cmp.supply_ok && cmp.bat_low_rech && !sel_rise &&
            CHARGE_MODE_SELECT_I == CSF_SEL_NOTIFY |=> st_q == ST_DONE &&
            flags_q.recharge_needed_flag;
    endproperty
    a_notify: assert property (p_notify) else $error("recharge notify wrong");
    property p_chg_exp;
        (st_q == ST_CHARGE) && saf_done |-> s_hiz_next and
            ##1 (flags_q.charge_timer_expired_flag && REG_DEFAULT_O);
    endproperty
    a_chg_exp: assert property (p_chg_exp) else $error("charge expiry wrong");
    property p_sink;
        (st_q == ST_DETECT) |=> DET_SINK_EN_O;
    endproperty
    a_sink: assert property (p_sink) else $error("sink not on");
    property p_sleep;
        (st_q == ST_CHARGE) && cmp.sleep |=> !PWM_EN_O && !REV_SWITCH_EN_O;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep left switches on");
    property p_bst_ovp;
        (st_q == ST_BOOST) && cmp.out_ov |-> s_hiz_next;
    endproperty
    a_bst_ovp: assert property (p_bst_ovp) else $error("boost ovp missed");
    property p_ind_low;
        (IND_SELECT_I == CSF_IND_LOW) [*2] |-> !IND_OE_N_O;
    endproperty
    a_ind_low: assert property (p_ind_low) else $error("indicator not low");
    property p_alert;
        |(flags_q & ~FLAG_MASK_I) |=> !ALERT_OE_N_O;
    endproperty
    a_alert: assert property (p_alert) else $error("alert not driven");
endmodule // csf_supervisor

// file: logic/csf_timer.sv
// loadable down-counter with a one-cycle expiry indication
module csf_timer #(
    parameter int W = 40
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // control
    input wire logic load_i,
    input wire logic [W-1:0] count_i,
    input wire logic run_i,
    // expiry, count_i cycles of run after load
    output logic done_o
);
    logic [W-1:0] cnt_q, cnt_d; // remaining cycles
    logic armed_q, armed_d;     // timer live

    // load restarts; stopping run freezes the count
    always_comb begin
        cnt_d = cnt_q;
        armed_d = armed_q;
        if (load_i) begin
            cnt_d = count_i - 1'b1;
            armed_d = 1'b1;
        end else if (run_i && armed_q) begin
            if (cnt_q == '0) begin
                armed_d = 1'b0;
            end else begin
                cnt_d = cnt_q - 1'b1;
            end
        end
    end

    // registers only
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q <= '0;
            armed_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            armed_q <= armed_d;
        end
    end

    assign done_o = armed_q && run_i && !load_i && (cnt_q == '0);
endmodule // csf_timer

// file: tb/csf_host_model.sv
// host side model: keeps both safety timers refreshed with access pulses
module csf_host_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // refresh enable and access pulse
    input wire logic en_i,
    output logic access_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0; // cycles since the last access
    // one pulse every 50 cycles, far inside either timer
    always @(negedge clk_i) begin
        cnt <= (rst_i || cnt == 49) ? 0 : cnt + 1;
        access_o <= en_i && !rst_i && cnt == 49;
    end
endmodule // csf_host_model

// file: tb/csf_supervisor_tb_top.sv
// self-checking bench of the charger supervisor
module csf_supervisor_tb_top import csf_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0; // 40 MHz reference
    logic rst_i = 1'b1; // held for 12 cycles
    csf_cmp_s cmp = '0; // comparator levels
    csf_flags_s fclr = '0; // flag clear pulses
    csf_flags_s fmask = '0; // nothing masked
    csf_flags_s flags; // sticky flags seen
    logic [1:0] sel = 2'h0; // charge mode selector
    logic [1:0] ind = 2'h0; // indicator select
    logic [2:0] code = 3'h0; // threshold code
    logic host_en = 1'b0; // host refresh on
    logic term = 1'b1; // termination enable
    logic pin_en = 1'b0, pin_pol = 1'b0, pin_req = 1'b0; // pin boost path
    logic access, ind_oe_n, alert_oe_n, regdef, mv_sink, pwm, rev, chg, bst, hiz;
    logic [3:0] mv;
    int num_errors = 0;
    int num_checks = 0;
    int ticks = 0; // hang guard
    // clock generator
    initial begin
        forever #12.5 clk_i = ~clk_i;
    end
    // short counts keep the run brief
    csf_supervisor #(.CHG_TIMER_CYC(200), .BST_TIMER_CYC(100), .DET_CYC(20), .RETRY_CYC(40), .OL_CYC(15)) dut (
        .CLOCK_I(clk_i), .RST_I(rst_i), .CMP_I(cmp), .CHARGE_MODE_SELECT_I(sel), .TERM_ENABLE_I(term),
        .EOC_THRESHOLD_CODE_I(code), .IND_SELECT_I(ind), .PIN_BOOST_ENABLE_I(pin_en),
        .PIN_BOOST_POLARITY_I(pin_pol), .BOOST_REQUEST_PIN_I(pin_req), .HOST_ACCESS_I(access),
        .FLAG_CLEAR_I(fclr), .FLAG_MASK_I(fmask), .FLAGS_O(flags), .ALERT_O(), .ALERT_OE_N_O(alert_oe_n),
        .IND_O(), .IND_OE_N_O(ind_oe_n), .EOC_THRESHOLD_MV_O(mv), .DET_SINK_EN_O(mv_sink), .PWM_EN_O(pwm),
        .REV_SWITCH_EN_O(rev), .REG_DEFAULT_O(regdef), .CHARGING_O(chg), .BOOST_O(bst), .HIZ_O(hiz));
    csf_host_model host (.clk_i(clk_i), .rst_i(rst_i), .en_i(host_en), .access_o(access));
    // compare and count
    task automatic chk(input string nm, input logic [3:0] exp, input logic [3:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // inputs move on the falling edge only; a defaults pulse clears the selector and termination enable
    task automatic cyc(input int n);
        repeat (n) begin
            @(negedge clk_i);
            if (regdef === 1'b1) begin
                sel = 2'h0; // selector and termination back to defaults
                term = 1'b0;
            end
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // hang guard, about three times the expected run
    always @(posedge clk_i) begin
        ticks <= ticks + 1;
        if (ticks == 3000) begin
            num_errors++;
            give_verdict();
        end
    end
    // main sequence
    initial begin
        cyc(12);
        rst_i = 1'b0;
        for (int i = 0; i < 8; i++) begin
            code = 3'(i);
            cyc(3);
            chk("eoc_mv", 4'(i) + 4'h1, mv);
        end
        term = 1'b0;
        cyc(3);
        chk("eoc_off", 4'h0, mv);
        term = 1'b1;
        host_en = 1'b1;
        sel = CSF_SEL_AUTO;
        cmp.supply_ok = 1'b1;
        cyc(15);
        chk("sink_on", 4'h1, {3'h0, mv_sink});
        cyc(30);
        chk("sink_off", 4'h0, {3'h0, mv_sink});
        chk("charging", 4'h1, {3'h0, chg});
        chk("ind_status", 4'h0, {3'h0, ind_oe_n});
        cyc(300);
        chk("refreshed", 4'h1, {3'h0, chg});
        cmp.sleep = 1'b1;
        cyc(14);
        chk("sleep_pwm_rev", 4'h0, {2'h0, pwm, rev});
        chk("alert_on", 4'h0, {3'h0, alert_oe_n});
        cmp.sleep = 1'b0;
        cyc(14);
        // clear pulse drops the flag, then the alert
        fclr.sleep_condition_flag = 1'b1;
        cyc(1);
        fclr = '0;
        cyc(3);
        chk("flag_clear", 4'h1, {2'h0, flags.sleep_condition_flag, alert_oe_n});
        // termination in constant-voltage phase
        cmp.cv_mode = 1'b1;
        cmp.below_term = 1'b1;
        cyc(14);
        chk("terminated", 4'h0, {3'h0, chg});
        sel = CSF_SEL_NOTIFY;
        cmp.below_term = 1'b0;
        cmp.bat_low_rech = 1'b1;
        cyc(14);
        chk("recharge_notify", 4'h1, {2'h0, chg, flags.recharge_needed_flag});
        sel = CSF_SEL_AUTO;
        cyc(3);
        chk("recharge_auto", 4'h1, {3'h0, chg});
        host_en = 1'b0;
        cyc(260);
        chk("chg_expiry", 4'h3, {2'h0, hiz, flags.charge_timer_expired_flag});
        chk("chg_defaults", 4'h0, {2'h0, sel});
        ind = CSF_IND_LOW;
        cyc(3);
        chk("ind_low", 4'h0, {3'h0, ind_oe_n});
        ind = CSF_IND_HIZ;
        cyc(3);
        chk("ind_hiz", 4'h1, {3'h0, ind_oe_n});
        host_en = 1'b1;
        sel = CSF_SEL_BOOST;
        cyc(15);
        chk("boost_on", 4'h1, {3'h0, bst});
        // output overvoltage: high-z two edges after the filtered trip
        cmp.out_ov = 1'b1;
        cyc(12);
        chk("bst_ovp", 4'h3, {2'h0, hiz, flags.boost_output_overvoltage_flag});
        cmp.out_ov = 1'b0;
        cyc(14);
        host_en = 1'b0;
        cyc(160);
        chk("bst_expiry", 4'h3, {2'h0, hiz, flags.boost_timer_expired_flag});
        chk("bst_defaults", 4'h0, {2'h0, sel});
        // pin path: edge onto the polarity level, then hold it
        host_en = 1'b1;
        pin_en = 1'b1;
        pin_pol = 1'b1;
        cyc(2);
        pin_req = 1'b1;
        cyc(5);
        chk("pin_boost", 4'h1, {3'h0, bst});
        pin_req = 1'b0;
        cyc(3);
        chk("pin_release", 4'h0, {3'h0, bst});
        give_verdict();
    end
endmodule // csf_supervisor_tb_top
